// ### core_timer_pkg.sv
// Package for the core timer and watchdog block: register map, field layout,
// reset values and timing counts.
// Assumes a 32-bit APB register bus and a single 125 MHz clock.
package core_timer_pkg;

  // ----------------------------------------------------------------------
  // Register byte addresses
  // ----------------------------------------------------------------------
  localparam logic [11:0] ADDR_STATUS_CONTROL = 12'h000;  // core_timer_status_control
  localparam logic [11:0] ADDR_COUNT          = 12'h004;  // core_timer_count
  localparam logic [11:0] ADDR_WATCHDOG_SEC   = 12'h008;  // watchdog_and_security

  // ----------------------------------------------------------------------
  // Status/control field positions
  // ----------------------------------------------------------------------
  localparam int BIT_OVERFLOW_FLAG       = 7;
  localparam int BIT_PERIODIC_FLAG       = 6;
  localparam int BIT_OVERFLOW_IRQ_ENABLE = 5;
  localparam int BIT_PERIODIC_IRQ_ENABLE = 4;
  localparam int BIT_OVERFLOW_FLAG_CLEAR = 3;
  localparam int BIT_PERIODIC_FLAG_CLEAR = 2;
  localparam int BIT_RATE_SELECT_HI      = 1;
  localparam int BIT_RATE_SELECT_LO      = 0;

  // ----------------------------------------------------------------------
  // Watchdog/security field positions
  // ----------------------------------------------------------------------
  localparam int BIT_PROGRAM_MEMORY_LOCK = 2;
  localparam int BIT_OPTIONAL_FEATURES   = 1;
  localparam int BIT_WATCHDOG_CLEAR      = 0;

  // ----------------------------------------------------------------------
  // Reset values and structure
  // ----------------------------------------------------------------------
  localparam logic [1:0] RATE_RESET      = 2'h3;  // Longest period
  localparam int         CHAIN_STAGES    = 15;    // Ripple counter stages
  localparam int         PRESCALE_DIV    = 8;     // Fixed oscillator prescaler
  localparam int         WATCHDOG_STAGES = 4;     // Stages after the chain
  localparam int         WD_TIMEOUT_TICKS = 8;    // Ticks from clear to expiry, partial first one counted
  localparam int         STARTUP_SHORT   = 16;    // Bus cycles
  localparam int         STARTUP_LONG    = 4064;  // Bus cycles
  localparam int         OSC_PER_BUS     = 2;     // Bus clock is oscillator / 2
  localparam int         RESET_PULSE_NS  = 64;    // Reset request length
  localparam int         CLK_PERIOD_NS   = 8;
  localparam int         RESET_PULSE_CYC = (RESET_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Interrupt request pair carried to the CPU core
  typedef struct packed {
    logic overflow;
    logic periodic;
  } irq_req_s;

endpackage

// ### core_timer_watchdog.sv
// Core timer with periodic tick and watchdog, APB slave.
// Assumes pclk acts as the oscillator, option bits are static straps and
// power-saving inputs come from logic on pclk; the high-voltage detect is a pin.
//
// What this block does
// - Periodic irq enable gates request, reset clears
// - Writing one clears overflow flag, reads zero
// - Writing one clears periodic flag, reads zero
// - Rate field picks osc/2^15..2^18
// - Selected tick also clocks the watchdog
// - Reset sets rate field to longest
// - Watchdog times out after 7-8 ticks
// - Fifteen stage chain after divide-by-eight prescaler
// - Low eight stages readable without disturbance
// - Chain clears at power-on and after startup
// - Count every eight cycles, overflow every 2048
// - Overflow flag set on wrap, gated, reset-cleared
// - Periodic flag set on tick, gated, reset-cleared
// - Four-stage watchdog, option enabled, resets chip
// - Writing zero to clear bit restarts watchdog
// - Runs in wait/halt; stop clears and halts it
// - Stop-to-halt option keeps watchdog running
// - High-voltage detect forces watchdog off
// - Write-only program memory lock bit
// - Optional features enable bit drives output
//
// Decided for this implementation: the APB register port and the address map.
`timescale 1ns/100ps

module core_timer_watchdog
  import core_timer_pkg::*;
#(
  parameter int STARTUP_LONG_CYC = STARTUP_LONG * OSC_PER_BUS  // Long startup in pclk cycles
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        watchdog_option_enable,  // Option: watchdog on
  input  wire logic        stop_to_halt_option,     // Option: stop acts as halt
  input  wire logic        startup_long_option,     // Option: long startup delay
  input  wire logic        stop_exec,               // Stop instruction pulse
  input  wire logic        wake_up,                 // Leaving stop mode
  input  wire logic        high_voltage_detect,     // Pin above 1.5 x supply
  output irq_req_s         irq_req,                 // Interrupt requests
  output logic             system_reset_req,        // Watchdog/startup reset
  output logic             program_memory_lock,     // Memory readout lock
  output logic             optional_features_enable // Optional features on
);

  // ----------------------------------------------------------------------
  // Local constants
  // ----------------------------------------------------------------------
  localparam int          PS_W      = $clog2(PRESCALE_DIV);
  localparam int          SU_W      = $clog2(STARTUP_LONG * OSC_PER_BUS + 1);
  localparam logic [SU_W-1:0] SU_SHORT = SU_W'(STARTUP_SHORT * OSC_PER_BUS);
  localparam logic [3:0]  RST_CYC   = 4'(RESET_PULSE_CYC);
  // Expiry on the tick that finds this count: the first tick after a clear
  // comes within one period, so expiry lands seven to eight periods later
  localparam logic [WATCHDOG_STAGES-1:0] WD_LAST = WATCHDOG_STAGES'(WD_TIMEOUT_TICKS - 1);

  typedef enum logic [1:0] {ST_POWER_UP, ST_RUN, ST_STOPPED, ST_RESETTING} mode_e;

  // ----------------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------------
  mode_e                       mode_r;          // Chip power/reset mode
  logic [PS_W-1:0]             prescale_r;      // Divide-by-eight prescaler
  logic [CHAIN_STAGES-1:0]     chain_r;         // Ripple counter chain
  logic [WATCHDOG_STAGES-1:0]  wd_r;            // Watchdog stages
  logic [SU_W-1:0]             startup_r;       // Startup delay count
  logic [3:0]                  rst_cnt_r;       // Reset pulse length
  logic                        overflow_flag_r; // Counter wrap flag
  logic                        periodic_flag_r; // Tick flag
  logic                        ovf_en_r;        // Overflow irq enable
  logic                        per_en_r;        // Periodic irq enable
  logic [1:0]                  rate_r;          // Tick rate select
  logic                        hv_meta_r;       // Pin sync, first stage
  logic                        hv_sync_r;       // Pin sync, second stage
  logic                        running;         // Chain advances
  logic                        chain_step;      // Chain increments now
  logic [CHAIN_STAGES:0]       chain_nxt;       // Chain with carry out
  logic                        wrap_evt;        // Low eight stages wrap
  logic                        tick_evt;        // Selected tick edge
  logic                        wd_active;       // Watchdog may count
  logic                        wd_timeout;      // Watchdog expiry
  logic                        wr_acc;          // APB write access
  logic                        rd_acc;          // APB read access
  logic                        wr_ctl;          // Write to status/control
  logic                        wr_wd;           // Write to watchdog/security
  logic                        watchdog_clear;  // Clear strobe
  logic                        stop_now;        // Stop instruction taken

  // Carry out of chain bit n: bit n and all lower bits ones
  function automatic logic carry_at(input logic [CHAIN_STAGES-1:0] c, input int n);
    logic r;
    r = 1'b1;
    for (int i = 0; i < CHAIN_STAGES; i++) begin
      if (i <= n) begin
        r = r & c[i];
      end
    end
    return r;
  endfunction

  // ----------------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------------
  assign wr_acc         = psel & penable & pwrite;
  assign rd_acc         = psel & penable & ~pwrite;
  assign wr_ctl         = wr_acc & (paddr == ADDR_STATUS_CONTROL) & pstrb[0];
  assign wr_wd          = wr_acc & (paddr == ADDR_WATCHDOG_SEC) & pstrb[0];
  assign watchdog_clear = wr_wd & ~pwdata[BIT_WATCHDOG_CLEAR];

  // ----------------------------------------------------------------------
  // Counter chain events
  // ----------------------------------------------------------------------
  assign running    = (mode_r == ST_RUN) || (mode_r == ST_POWER_UP);
  assign chain_step = running && (prescale_r == PS_W'(PRESCALE_DIV - 1));
  assign chain_nxt  = {1'b0, chain_r} + {{CHAIN_STAGES{1'b0}}, 1'b1};
  assign wrap_evt   = chain_step && carry_at(chain_r, 7);
  // Tick from stage 15..18 of the oscillator: 3 prescale + 12..15 chain bits
  assign tick_evt   = chain_step && carry_at(chain_r, 11 + int'(rate_r));
  assign wd_active  = watchdog_option_enable && !hv_sync_r && (mode_r == ST_RUN);
  assign wd_timeout = wd_active && tick_evt && (wd_r == WD_LAST) && !watchdog_clear;
  assign stop_now   = (mode_r == ST_RUN) && stop_exec && !stop_to_halt_option;

  // ----------------------------------------------------------------------
  // High-voltage detect synchroniser
  // ----------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hv_meta_r <= 1'b0;
      hv_sync_r <= 1'b0;
    end else begin
      hv_meta_r <= high_voltage_detect;
      hv_sync_r <= hv_meta_r;
    end
  end

  // ----------------------------------------------------------------------
  // Mode machine: power-up delay, run, stop, watchdog reset
  // ----------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_r    <= ST_POWER_UP;
      startup_r <= '0;
      rst_cnt_r <= '0;
    end else begin
      case (mode_r)
        ST_POWER_UP: begin
          startup_r <= startup_r + 1'b1;
          if (startup_r == (startup_long_option ? SU_W'(STARTUP_LONG_CYC) : SU_SHORT) - 1'b1) begin
            mode_r <= ST_RUN;
          end
        end
        ST_RUN: begin
          if (wd_timeout) begin
            mode_r    <= ST_RESETTING;
            rst_cnt_r <= '0;
          end else if (stop_now) begin
            mode_r <= ST_STOPPED;
          end
        end
        ST_STOPPED: begin
          if (wake_up) begin
            mode_r <= ST_RUN;
          end
        end
        ST_RESETTING: begin
          rst_cnt_r <= rst_cnt_r + 1'b1;
          if (rst_cnt_r == RST_CYC - 1'b1) begin
            mode_r    <= ST_POWER_UP;
            startup_r <= '0;
          end
        end
        default: mode_r <= ST_POWER_UP;
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Prescaler and counter chain
  // ----------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prescale_r <= '0;
      chain_r    <= '0;
    end else if ((mode_r == ST_POWER_UP) && (startup_r == (startup_long_option ?
                 SU_W'(STARTUP_LONG_CYC) : SU_SHORT) - 1'b1)) begin
      prescale_r <= '0;
      chain_r    <= '0;
    end else if (mode_r == ST_RESETTING) begin
      prescale_r <= '0;
      chain_r    <= '0;
    end else if (running) begin
      prescale_r <= prescale_r + 1'b1;
      if (chain_step) begin
        chain_r <= chain_nxt[CHAIN_STAGES-1:0];
      end
    end
  end

  // ----------------------------------------------------------------------
  // Watchdog stages, clocked by the selected tick
  // ----------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wd_r <= '0;
    end else if (watchdog_clear || !wd_active || stop_now) begin
      wd_r <= '0;
    end else if (tick_evt) begin
      wd_r <= wd_r + 1'b1;
    end
  end

  // ----------------------------------------------------------------------
  // Flags: set wins over a clear in the same cycle
  // ----------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      overflow_flag_r <= 1'b0;
      periodic_flag_r <= 1'b0;
    end else if ((mode_r == ST_RESETTING) || (mode_r == ST_POWER_UP)) begin
      // Chip is held in reset during startup, so wraps there leave no flag
      overflow_flag_r <= 1'b0;
      periodic_flag_r <= 1'b0;
    end else begin
      if (wrap_evt) begin
        overflow_flag_r <= 1'b1;
      end else if (wr_ctl && pwdata[BIT_OVERFLOW_FLAG_CLEAR]) begin
        overflow_flag_r <= 1'b0;
      end
      if (tick_evt) begin
        periodic_flag_r <= 1'b1;
      end else if (wr_ctl && pwdata[BIT_PERIODIC_FLAG_CLEAR]) begin
        periodic_flag_r <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Control bits and watchdog/security register
  // ----------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ovf_en_r                 <= 1'b0;
      per_en_r                 <= 1'b0;
      rate_r                   <= RATE_RESET;
      program_memory_lock      <= 1'b0;
      optional_features_enable <= 1'b0;
    end else if (mode_r == ST_RESETTING) begin
      ovf_en_r <= 1'b0;
      per_en_r <= 1'b0;
      rate_r   <= RATE_RESET;
    end else begin
      if (wr_ctl) begin
        ovf_en_r <= pwdata[BIT_OVERFLOW_IRQ_ENABLE];
        per_en_r <= pwdata[BIT_PERIODIC_IRQ_ENABLE];
        rate_r   <= pwdata[BIT_RATE_SELECT_HI:BIT_RATE_SELECT_LO];
      end
      if (wr_wd) begin
        program_memory_lock      <= pwdata[BIT_PROGRAM_MEMORY_LOCK];
        optional_features_enable <= pwdata[BIT_OPTIONAL_FEATURES];
      end
    end
  end

  // ----------------------------------------------------------------------
  // Registered outputs: interrupts, reset request, APB answer
  // ----------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_req          <= '0;
      system_reset_req <= 1'b1;
      prdata           <= '0;
      pready           <= 1'b0;
      pslverr          <= 1'b0;
    end else begin
      irq_req.overflow <= overflow_flag_r & ovf_en_r;
      irq_req.periodic <= periodic_flag_r & per_en_r;
      system_reset_req <= (mode_r == ST_RESETTING) || (mode_r == ST_POWER_UP);
      pready           <= psel & ~penable;
      pslverr          <= 1'b0;
      prdata           <= '0;
      if (psel && !penable && !pwrite) begin
        case (paddr)
          ADDR_STATUS_CONTROL: prdata[7:0] <= {overflow_flag_r, periodic_flag_r, ovf_en_r,
                                               per_en_r, 2'b00, rate_r};
          ADDR_COUNT:          prdata[7:0] <= chain_r[7:0];
          default:             prdata      <= '0;
        endcase
      end else if (psel && !penable) begin
        pslverr <= 1'b0;
      end
      if (psel && !penable && (paddr != ADDR_STATUS_CONTROL) && (paddr != ADDR_COUNT) &&
          (paddr != ADDR_WATCHDOG_SEC)) begin
        pslverr <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  sequence s_cleared;
    watchdog_clear;
  endsequence

  chk_wd_clear_zero: assert property (@(posedge pclk) disable iff (!presetn)
    s_cleared |=> (wd_r == '0)) else $error("watchdog not restarted by clear");
  chk_hv_forces_off: assert property (@(posedge pclk) disable iff (!presetn)
    hv_sync_r |=> (wd_r == '0)) else $error("watchdog counts during high voltage");
  chk_ovf_flag_set: assert property (@(posedge pclk) disable iff (!presetn)
    (wrap_evt && mode_r == ST_RUN) |=> overflow_flag_r) else $error("overflow flag not set");
  chk_tick_flag_set: assert property (@(posedge pclk) disable iff (!presetn)
    (tick_evt && mode_r == ST_RUN) |=> periodic_flag_r) else $error("periodic flag not set");
  chk_ovf_clear: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_ctl && pwdata[BIT_OVERFLOW_FLAG_CLEAR] && !wrap_evt) |=> !overflow_flag_r)
    else $error("overflow flag not cleared");
  chk_rate_reset: assert property (@(posedge pclk) disable iff (!presetn)
    (mode_r == ST_RESETTING) |=> (rate_r == RATE_RESET)) else $error("rate not longest after reset");
  chk_timeout_reset: assert property (@(posedge pclk) disable iff (!presetn)
    wd_timeout |=> (mode_r == ST_RESETTING) ##1 system_reset_req) else $error("timeout without reset");
  chk_stop_halts: assert property (@(posedge pclk) disable iff (!presetn)
    (mode_r == ST_STOPPED) |-> (wd_r == '0) && !chain_step) else $error("watchdog active in stop");
  chk_step_spacing: assert property (@(posedge pclk) disable iff (!presetn)
    chain_step |=> !chain_step [*7]) else $error("count step faster than eight cycles");

  // Stop takes the watchdog down with it; startup leaves no stale flags
  sequence s_stopping;
    stop_now;
  endsequence

  chk_stop_clears: assert property (@(posedge pclk) disable iff (!presetn)
    s_stopping |=> (wd_r == '0)) else $error("watchdog kept through stop");
  chk_flags_startup: assert property (@(posedge pclk) disable iff (!presetn)
    (mode_r == ST_POWER_UP) |=> !overflow_flag_r && !periodic_flag_r) else $error("flag set during startup");

endmodule

// ### apb_host_model.sv
// ----------------------------------------------------------------
// APB host model standing in for the CPU core
// ----------------------------------------------------------------
// Assumes a zero or more wait state slave that answers with pready.
`timescale 1ns/100ps

module apb_host_model (
  input  wire logic        pclk,
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic [11:0]      paddr,
  output logic [31:0]      pwdata,
  output logic [3:0]       pstrb,
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  input  wire logic        pslverr
);
  // Idle bus at time zero
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    pstrb = 4'hF;
  end

  // One transfer: setup, access held until pready, then release
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] r, output logic e);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    // Wait for the answer; only the bench timeout ends a hang
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
endmodule

// ### tb_core_timer_watchdog.sv
// ----------------------------------------------------------------
// Self-checking bench for the core timer and watchdog
// ----------------------------------------------------------------
// Assumes the long startup count is shortened to 64 cycles.
`timescale 1ns/100ps

module tb_core_timer_watchdog;
  import core_timer_pkg::*;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd, rd2;
  logic [3:0]  pstrb;
  logic        hv_detect, sys_rst, mem_lock, opt_en;
  logic        stop_halt_opt, stop_pulse, wake_pulse;
  irq_req_s    irq_req;
  int          miscompares, comparisons;

  core_timer_watchdog #(.STARTUP_LONG_CYC(64)) dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .watchdog_option_enable(1'b1), .stop_to_halt_option(stop_halt_opt),
    .startup_long_option(1'b1), .stop_exec(stop_pulse), .wake_up(wake_pulse),
    .high_voltage_detect(hv_detect), .irq_req(irq_req),
    .system_reset_req(sys_rst), .program_memory_lock(mem_lock),
    .optional_features_enable(opt_en));

  apb_host_model host (.pclk, .psel, .penable, .pwrite, .paddr, .pwdata,
                       .pstrb, .prdata, .pready, .pslverr);

  // Clock, 8 ns period
  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    host.xfer(1'b1, a, d, rd, err);
  endtask

  task automatic rdreg(input logic [11:0] a);
    host.xfer(1'b0, a, 32'h0, rd, err);
  endtask

  task automatic end_sim;
    if (miscompares == 0 && comparisons > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  // Reset request through startup, then reset register values
  task automatic t_reset;
    int n;
    chk(sys_rst, 1'b1);
    presetn <= 1'b1;
    for (n = 0; n < 200 && sys_rst !== 1'b0; n++) @(posedge pclk);
    chk(n >= 60 && n <= 70, 1'b1);
    rdreg(ADDR_STATUS_CONTROL);
    chk(rd, {30'h0, RATE_RESET});
  endtask

  // Count steps once every eight cycles, reads leave it running
  task automatic t_count;
    rdreg(ADDR_COUNT);
    rd2 = rd;
    repeat (61) @(posedge pclk);
    rdreg(ADDR_COUNT);
    chk((rd - rd2) & 32'hFF, 32'h8);
    chk(rd[31:8], 24'h0);
  endtask

  // Overflow flag, its request, a zero write and a one write to clear
  task automatic t_overflow;
    int n;
    wr(ADDR_WATCHDOG_SEC, 32'h0);
    wr(ADDR_STATUS_CONTROL, 32'h20);
    for (n = 0; n < 2200 && irq_req.overflow !== 1'b1; n++) @(posedge pclk);
    chk(irq_req.overflow, 1'b1);
    rdreg(ADDR_COUNT);
    chk(rd[7:0] < 8'h02, 1'b1);
    wr(ADDR_STATUS_CONTROL, 32'h20);
    rdreg(ADDR_STATUS_CONTROL);
    chk(rd[7], 1'b1);
    wr(ADDR_STATUS_CONTROL, 32'h28);
    rdreg(ADDR_STATUS_CONTROL);
    chk(rd, 32'h20);
    chk(irq_req.overflow, 1'b0);
  endtask

  // Periodic flag at the fastest rate, gating and clearing
  task automatic t_periodic;
    int n;
    wr(ADDR_STATUS_CONTROL, 32'h10);
    hv_detect <= 1'b1;
    repeat (20) @(posedge pclk);
    hv_detect <= 1'b0;
    for (n = 0; n < 34000 && irq_req.periodic !== 1'b1; n++) @(posedge pclk);
    chk(irq_req.periodic, 1'b1);
    chk(sys_rst, 1'b0);
    wr(ADDR_STATUS_CONTROL, 32'h00);
    rdreg(ADDR_STATUS_CONTROL);
    chk(rd[6], 1'b1);
    chk(irq_req.periodic, 1'b0);
    wr(ADDR_STATUS_CONTROL, 32'h04);
    rdreg(ADDR_STATUS_CONTROL);
    chk({rd[6], rd[2]}, 2'b00);
  endtask

  // Every rate code written and read back
  task automatic t_rates;
    for (int r = 0; r < 4; r++) begin
      wr(ADDR_WATCHDOG_SEC, 32'h0);
      wr(ADDR_STATUS_CONTROL, r);
      rdreg(ADDR_STATUS_CONTROL);
      chk(rd[1:0], r[1:0]);
    end
  endtask

  // Write-only lock and feature bits, then an unmapped address
  task automatic t_wdsec;
    wr(ADDR_WATCHDOG_SEC, 32'h06);
    rdreg(ADDR_WATCHDOG_SEC);
    chk(rd, 32'h0);
    chk(mem_lock, 1'b1);
    chk(opt_en, 1'b1);
    host.xfer(1'b0, 12'h00C, 32'h0, rd, err);
    chk(err, 1'b1);
    chk(rd, 32'h0);
  endtask

  // Stop as halt keeps counting; a real stop freezes the chain until wake-up
  task automatic t_stop;
    wr(ADDR_WATCHDOG_SEC, 32'h0);
    stop_halt_opt <= 1'b1;
    stop_pulse <= 1'b1;
    @(posedge pclk);
    stop_pulse <= 1'b0;
    rdreg(ADDR_COUNT);
    rd2 = rd;
    repeat (13) @(posedge pclk);
    rdreg(ADDR_COUNT);
    chk((rd - rd2) & 32'hFF, 32'h2);
    stop_halt_opt <= 1'b0;
    stop_pulse <= 1'b1;
    @(posedge pclk);
    stop_pulse <= 1'b0;
    rdreg(ADDR_COUNT);
    rd2 = rd;
    repeat (13) @(posedge pclk);
    rdreg(ADDR_COUNT);
    chk(rd, rd2);
    wake_pulse <= 1'b1;
    @(posedge pclk);
    wake_pulse <= 1'b0;
    rdreg(ADDR_COUNT);
    rd2 = rd;
    repeat (13) @(posedge pclk);
    rdreg(ADDR_COUNT);
    chk((rd - rd2) & 32'hFF, 32'h2);
  endtask

  // Main sequence
  initial begin
    presetn = 1'b0;
    hv_detect = 1'b0;
    stop_halt_opt = 1'b0;
    stop_pulse = 1'b0;
    wake_pulse = 1'b0;
    miscompares = 0;
    comparisons = 0;
    repeat (4) @(posedge pclk);
    t_reset;
    t_count;
    t_overflow;
    t_periodic;
    t_rates;
    t_wdsec;
    t_stop;
    end_sim;
  end

  // Watchdog against a hang, about twice the expected run
  initial begin
    #600000;
    miscompares++;
    end_sim;
  end
endmodule
